// ### rtl/ppfs_port_pin_function_select.sv
// pin function selection and port registers for the general-purpose ports
// Behaviour
// RULE_01: twelve bidirectional ports with direction bits, one input-only port without.
// RULE_02: each port has an output latch and a readable pin-state view.
// RULE_03: ports A to E have per-pin pull-up control bits.
// RULE_04: ports 3 and A have per-pin open-drain bits disabling high-side drive.
// RULE_05: upper port A drives address when direction and enable set, else latch.
// RULE_06: lower port A: address in modes 4,5; in 6 when direction set.
// RULE_07: port F clock pin: direction picks clock output; reset default per mode.
// RULE_08: address strobe pin is strobe output unless disabled; plain I/O in mode 7.
// RULE_09: port F multi pin plain I/O by default; wait input when wait enabled.
// RULE_10: port F multi pin outputs low column strobe for dram types 1-3, 16-bit.
// RULE_11: bus release enable turns port F pins into request input, acknowledge output.
// RULE_12: port 5 pin outputs bus drop request when selected and enabled, wait off.
// RULE_13: port G chip select 0 follows direction; reset direction 1 in 4,5, else 0.
// RULE_14: chip select 1 pin outputs select when enabled, else general output.
// RULE_15: chip select 2,3 pins output selects when enabled and direction set.
// RULE_16: rom-less variants never take the mode 6 or 7 choices.
// RULE_17: direction bit 1 makes a pin output, 0 makes it input.
// RULE_18: pin-state read gives latch for outputs and pin level for inputs.
// RULE_19: selection is combinational; peripheral functions beat general output. Here the selected values pass through flops and reach the pins a cycle later.
// RULE_20: control bits reset so each pin takes its after-reset function.
module ppfs_port_pin_function_select
  import ppfs_pkg::*;
#(
  parameter int PORT_W = PPFS_PW,
  parameter bit ROMLESS = 1'h0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [2:0] mode_pins,
  input wire ppfs_wr_t wr,
  input wire ppfs_ctrl_t ctrl,
  input wire ppfs_bus_t bus,
  input wire ppfs_port_arr_t pin_in,
  output ppfs_port_arr_t pin_out,
  output ppfs_port_arr_t pin_oe,
  output ppfs_port_arr_t pin_pullup_en,
  output ppfs_port_arr_t pin_state,
  output ppfs_fn_in_t fn_in,
  output logic [1:0] mode_active
);

  // refuse a port width the pin map cannot serve
  if (PORT_W != PPFS_PW) begin : g_width_check
    $error("ppfs: port width must be 8");
  end

  typedef struct packed {
    logic [2:0] md_s1;
    logic [2:0] md_s2;
    logic [2:0] md_s3;
    logic [1:0] settle;
    logic init_done;
    logic [1:0] mode;
    ppfs_port_arr_t s1;
    ppfs_port_arr_t s2;
    ppfs_port_arr_t s3;
    ppfs_port_arr_t filt;
    ppfs_port_arr_t latch;
    ppfs_port_arr_t dir;
    logic [4:0][7:0] pullup_control;
    logic [1:0][7:0] open_drain_control;
    ppfs_port_arr_t out;
    ppfs_port_arr_t oe;
    ppfs_port_arr_t pu;
    ppfs_port_arr_t state;
    ppfs_fn_in_t fn;
  } ppfs_state_t;

  ppfs_state_t q;
  ppfs_state_t d;
  logic [1:0] rst_sync_q;
  logic rst_int_n;

  logic [1:0] mode_c;
  logic m45;
  logic m6;
  logic ext;
  logic [7:0] en_a;
  logic low_column_strobe_on;
  logic drop_sel;
  logic drop_f2;
  logic drop_p5;
  logic wait_sel;
  logic wait_f2;
  logic wait_p5;
  ppfs_port_arr_t out_c;
  ppfs_port_arr_t oe_c;
  ppfs_fn_in_t fn_c;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rst_int_n = rst_sync_q[1];

  always_comb begin
    d = q;
    mode_c = q.mode;
    m45 = 1'h0;
    m6 = 1'h0;
    ext = 1'h0;
    en_a = 8'h00;
    low_column_strobe_on = 1'h0;
    drop_sel = 1'h0;
    drop_f2 = 1'h0;
    drop_p5 = 1'h0;
    wait_sel = 1'h0;
    wait_f2 = 1'h0;
    wait_p5 = 1'h0;
    out_c = q.latch;
    oe_c = q.dir; // RULE_17
    fn_c = PPFS_FN_IDLE;

    // three-stage pin sync; a bit changes only when stages two and three agree
    d.md_s1 = mode_pins;
    d.md_s2 = q.md_s1;
    d.md_s3 = q.md_s2;
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.filt = (q.s2 & ~(q.s2 ^ q.s3)) | (q.filt & (q.s2 ^ q.s3));

    // mode straps taken once after release, then the mode-dependent reset directions
    if (!q.init_done) begin
      if (q.settle != PPFS_SETTLE) begin
        d.settle = q.settle + 2'h1;
      end else if (q.md_s2 == q.md_s3) begin
        mode_c = {ROMLESS ? 1'h0 : q.md_s3[1], q.md_s3[0]}; // RULE_16
        d.mode = mode_c;
        d.init_done = 1'h1;
        d.dir[PPFS_PF][PPFS_F_CLK] = (mode_c != PPFS_MODE7); // RULE_07 RULE_20
        d.dir[PPFS_PG][PPFS_G_CS0] = (mode_c == PPFS_MODE4) || (mode_c == PPFS_MODE5); // RULE_13
      end
    end

    // software writes; ignored until the mode is known so reset directions hold
    if (wr.wr_en && q.init_done && (wr.port < 4'hD)) begin
      case (wr.kind)
        PPFS_WR_LATCH: begin
          d.latch[wr.port] = wr.data & PPFS_PORT_MASK[wr.port]; // RULE_02
        end
        PPFS_WR_DIR: begin
          d.dir[wr.port] = wr.data & PPFS_DIR_MASK[wr.port]; // RULE_01
        end
        PPFS_WR_PULLUP: begin
          if ((wr.port >= 4'(PPFS_PA)) && (wr.port <= 4'(PPFS_PE))) begin
            d.pullup_control[3'(wr.port - 4'(PPFS_PA))] = wr.data; // RULE_03
          end
        end
        PPFS_WR_ODRAIN: begin
          if (wr.port == 4'(PPFS_P3)) begin
            d.open_drain_control[0] = wr.data & PPFS_PORT_MASK[PPFS_P3]; // RULE_04
          end else if (wr.port == 4'(PPFS_PA)) begin
            d.open_drain_control[1] = wr.data; // RULE_04
          end
        end
        default: begin
        end
      endcase
    end

    // mode decode; before the straps are taken every pin stays plain input
    m45 = (q.mode == PPFS_MODE4) || (q.mode == PPFS_MODE5);
    m6 = (q.mode == PPFS_MODE6);
    ext = q.init_done && (q.mode != PPFS_MODE7);
    en_a = {ctrl.addr_line_enable_top, ctrl.addr_line_enable_low, 4'h0};

    // port A: upper half address or latch, lower half address by mode
    for (int i = 0; i < PPFS_PW; i++) begin
      if (i >= PPFS_A_UPPER_LO) begin
        if (ext && q.dir[PPFS_PA][i]) begin
          out_c[PPFS_PA][i] = en_a[i] ? bus.addr[16 + i] : q.latch[PPFS_PA][i]; // RULE_05
        end
        fn_c.irq_a_n[i - PPFS_A_UPPER_LO] = q.dir[PPFS_PA][i] | q.filt[PPFS_PA][i]; // RULE_05
      end else if (ext && m45) begin
        out_c[PPFS_PA][i] = bus.addr[16 + i]; // RULE_06
        oe_c[PPFS_PA][i] = 1'h1; // RULE_06
      end else if (ext && m6) begin
        out_c[PPFS_PA][i] = bus.addr[16 + i]; // RULE_06
      end
    end

    // ports B and C carry the low address in expanded modes
    if (ext) begin
      out_c[PPFS_PB] = bus.addr[15:8]; // RULE_19
      oe_c[PPFS_PB] = 8'hFF;
      out_c[PPFS_PC] = bus.addr[7:0];
      oe_c[PPFS_PC] = 8'hFF;
    end

    // port F clock pin: direction alone chooses input or clock output
    out_c[PPFS_PF][PPFS_F_CLK] = bus.sys_clk_out; // RULE_07

    // address strobe pin
    if (ext && !ctrl.addr_strobe_disable) begin
      out_c[PPFS_PF][PPFS_F_AS] = bus.address_strobe_n; // RULE_08
      oe_c[PPFS_PF][PPFS_F_AS] = 1'h1;
    end

    // multi-function pins: strobe first, then drop request, then wait input
    low_column_strobe_on = ext && ctrl.access_16bit && (ctrl.refresh_dram_type_field >= PPFS_DRAM_LO)
      && (ctrl.refresh_dram_type_field <= PPFS_DRAM_HI); // RULE_10
    drop_sel = ext && !ctrl.wait_input_enable && ctrl.bus_drop_out_enable; // RULE_12
    drop_f2 = drop_sel && !ctrl.bus_drop_pin_select;
    drop_p5 = drop_sel && ctrl.bus_drop_pin_select; // RULE_12
    wait_sel = ext && ctrl.wait_input_enable && !ctrl.bus_drop_out_enable; // RULE_09
    wait_f2 = wait_sel && !ctrl.wait_pin_select && !q.dir[PPFS_PF][PPFS_F_MULTI];
    wait_p5 = wait_sel && ctrl.wait_pin_select && !q.dir[PPFS_P5][PPFS_P5_MULTI];

    if (low_column_strobe_on) begin
      out_c[PPFS_PF][PPFS_F_MULTI] = bus.low_column_strobe_n; // RULE_10 RULE_19
      oe_c[PPFS_PF][PPFS_F_MULTI] = 1'h1;
    end else if (drop_f2) begin
      out_c[PPFS_PF][PPFS_F_MULTI] = bus.bus_drop_request_out_n; // RULE_19
      oe_c[PPFS_PF][PPFS_F_MULTI] = 1'h1;
    end
    if (drop_p5) begin
      out_c[PPFS_P5][PPFS_P5_MULTI] = bus.bus_drop_request_out_n; // RULE_12
      oe_c[PPFS_P5][PPFS_P5_MULTI] = 1'h1;
    end
    // wait level is only passed on while the chosen pin is an input
    if (wait_f2 && !low_column_strobe_on) begin
      fn_c.wait_n = q.filt[PPFS_PF][PPFS_F_MULTI]; // RULE_09
    end else if (wait_p5) begin
      fn_c.wait_n = q.filt[PPFS_P5][PPFS_P5_MULTI]; // RULE_09
    end

    // bus release pins
    if (ext && ctrl.bus_release_enable) begin
      oe_c[PPFS_PF][PPFS_F_EXTERNAL_BUS_REQUEST] = 1'h0; // RULE_11
      fn_c.external_bus_request_n = q.filt[PPFS_PF][PPFS_F_EXTERNAL_BUS_REQUEST];
      out_c[PPFS_PF][PPFS_F_BACK] = bus.bus_ack_n; // RULE_11
      oe_c[PPFS_PF][PPFS_F_BACK] = 1'h1;
    end

    // port G chip selects
    if (ext && (m45 || m6)) begin
      out_c[PPFS_PG][PPFS_G_CS0] = bus.chip_select_n[0]; // RULE_13
    end
    if (ext && ctrl.chip_select_1_6_7_enable) begin
      out_c[PPFS_PG][PPFS_G_CS1] = bus.chip_select_n[1]; // RULE_14
      oe_c[PPFS_PG][PPFS_G_CS1] = 1'h1;
    end
    if (ext && ctrl.chip_select_2_5_enable) begin
      out_c[PPFS_PG][PPFS_G_CS2] = bus.chip_select_n[2]; // RULE_15
      out_c[PPFS_PG][PPFS_G_CS3] = bus.chip_select_n[3]; // RULE_15
    end
    if (ext && ctrl.dram_space_set) begin
      out_c[PPFS_PG][PPFS_G_CAS] = bus.column_strobe_n;
      oe_c[PPFS_PG][PPFS_G_CAS] = 1'h1;
    end

    // trim missing pins; open drain drops drive while a high is wanted
    out_c = out_c & PPFS_PORT_MASK;
    oe_c = oe_c & PPFS_DIR_MASK; // RULE_01
    oe_c[PPFS_P3] = oe_c[PPFS_P3] & ~(q.open_drain_control[0] & out_c[PPFS_P3]); // RULE_04
    oe_c[PPFS_PA] = oe_c[PPFS_PA] & ~(q.open_drain_control[1] & out_c[PPFS_PA]); // RULE_04

    // pull-ups act only on pins not driven, and only on ports A to E
    d.pu = '0;
    for (int p = PPFS_PA; p <= PPFS_PE; p++) begin
      d.pu[p] = q.pullup_control[p - PPFS_PA] & ~oe_c[p]; // RULE_03
    end

    // pin-state view: latch for outputs, filtered level for inputs
    for (int p = 0; p < PPFS_NPORT; p++) begin
      d.state[p] = ((q.dir[p] & q.latch[p]) | (~q.dir[p] & q.filt[p]))
        & PPFS_PORT_MASK[p]; // RULE_18
    end

    d.out = out_c;
    d.oe = oe_c;
    d.fn = fn_c;
  end

  // all control bits reset to zero so pins come up as plain inputs
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      q <= '0; // RULE_20
      q.fn <= PPFS_FN_IDLE;
    end else if (ce) begin
      q <= d;
    end
  end

  // every output straight from the state flops
  assign pin_out = q.out;
  assign pin_oe = q.oe;
  assign pin_pullup_en = q.pu;
  assign pin_state = q.state;
  assign fn_in = q.fn;
  assign mode_active = q.mode;

endmodule // ppfs_port_pin_function_select

// ### rtl/ppfs_pkg.sv
// shared constants and types for the port pin function selector
package ppfs_pkg;

  // port count, width and index of each port in the pin arrays
  localparam int PPFS_NPORT = 13;
  localparam int PPFS_PW = 8;
  localparam int PPFS_P1 = 0;
  localparam int PPFS_P2 = 1;
  localparam int PPFS_P3 = 2;
  localparam int PPFS_P4 = 3;
  localparam int PPFS_P5 = 4;
  localparam int PPFS_P6 = 5;
  localparam int PPFS_PA = 6;
  localparam int PPFS_PB = 7;
  localparam int PPFS_PC = 8;
  localparam int PPFS_PD = 9;
  localparam int PPFS_PE = 10;
  localparam int PPFS_PF = 11;
  localparam int PPFS_PG = 12;

  typedef logic [PPFS_NPORT-1:0][PPFS_PW-1:0] ppfs_port_arr_t;

  // implemented pins per port; index 12 (port G) first
  localparam ppfs_port_arr_t PPFS_PORT_MASK = {8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'h3F, 8'hFF, 8'hFF};
  // pins that own a direction bit; the input-only port has none
  localparam ppfs_port_arr_t PPFS_DIR_MASK = {8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'h0F, 8'h00, 8'h3F, 8'hFF, 8'hFF};

  // operating mode codes, low two bits of the mode pins
  localparam logic [1:0] PPFS_MODE4 = 2'h0;
  localparam logic [1:0] PPFS_MODE5 = 2'h1;
  localparam logic [1:0] PPFS_MODE6 = 2'h2;
  localparam logic [1:0] PPFS_MODE7 = 2'h3;

  // bit positions of the shared pins
  localparam int PPFS_A_UPPER_LO = 4;
  localparam int PPFS_F_CLK = 7;
  localparam int PPFS_F_AS = 6;
  localparam int PPFS_F_MULTI = 2;
  localparam int PPFS_F_BACK = 1;
  localparam int PPFS_F_EXTERNAL_BUS_REQUEST = 0;
  localparam int PPFS_P5_MULTI = 3;
  localparam int PPFS_G_CS0 = 4;
  localparam int PPFS_G_CS1 = 3;
  localparam int PPFS_G_CS2 = 2;
  localparam int PPFS_G_CS3 = 1;
  localparam int PPFS_G_CAS = 0;

  // dram type codes that put the low column strobe out
  localparam logic [2:0] PPFS_DRAM_LO = 3'h1;
  localparam logic [2:0] PPFS_DRAM_HI = 3'h3;

  // cycles after reset release before the mode straps are taken
  localparam logic [1:0] PPFS_SETTLE = 2'h3;

  // write command targets, one-hot
  typedef enum logic [3:0] {
    PPFS_WR_LATCH = 4'h1,
    PPFS_WR_DIR = 4'h2,
    PPFS_WR_PULLUP = 4'h4,
    PPFS_WR_ODRAIN = 4'h8
  } ppfs_wr_kind_t;

  typedef struct packed {
    logic wr_en;
    ppfs_wr_kind_t kind;
    logic [3:0] port;
    logic [7:0] data;
  } ppfs_wr_t;

  typedef struct packed {
    logic [2:0] addr_line_enable_top;
    logic addr_line_enable_low;
    logic addr_strobe_disable;
    logic wait_input_enable;
    logic bus_drop_out_enable;
    logic wait_pin_select;
    logic bus_drop_pin_select;
    logic [2:0] refresh_dram_type_field;
    logic access_16bit;
    logic bus_release_enable;
    logic chip_select_1_6_7_enable;
    logic chip_select_2_5_enable;
    logic dram_space_set;
  } ppfs_ctrl_t;

  // peripheral signals that may take over pins
  typedef struct packed {
    logic [23:0] addr;
    logic sys_clk_out;
    logic address_strobe_n;
    logic low_column_strobe_n;
    logic column_strobe_n;
    logic bus_drop_request_out_n;
    logic bus_ack_n;
    logic [3:0] chip_select_n;
  } ppfs_bus_t;

  // pin levels handed to peripherals
  typedef struct packed {
    logic external_bus_request_n;
    logic wait_n;
    logic [3:0] irq_a_n;
  } ppfs_fn_in_t;

  localparam ppfs_fn_in_t PPFS_FN_IDLE = '{1'h1, 1'h1, 4'hF};

endpackage

// ### bench/ppfs_port_pin_function_select_asserts.sv
// concurrent checks on the port pin function selector ports
module ppfs_port_pin_function_select_asserts
  import ppfs_pkg::*;
#(
  parameter int PORT_W = PPFS_PW,
  parameter bit ROMLESS = 1'h0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [2:0] mode_pins,
  input wire ppfs_wr_t wr,
  input wire ppfs_ctrl_t ctrl,
  input wire ppfs_bus_t bus,
  input wire ppfs_port_arr_t pin_in,
  input wire ppfs_port_arr_t pin_out,
  input wire ppfs_port_arr_t pin_oe,
  input wire ppfs_port_arr_t pin_pullup_en,
  input wire ppfs_port_arr_t pin_state,
  input wire ppfs_fn_in_t fn_in,
  input wire logic [1:0] mode_active
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] up_q;
  logic rst_seen_q = 1'h0;
  logic rdy;
  logic m7;

  // mode capture needs a handful of cycles; checks wait until it is surely done
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_q <= 4'h0;
    end else if (up_q != 4'hF) begin
      up_q <= up_q + 4'h1;
    end
  end
  assign rdy = (up_q == 4'hF);

  // reset seen at an earlier edge; the very first edge still shows power-up unknowns
  always_ff @(posedge clk) begin
    rst_seen_q <= !rst_n;
  end
  assign m7 = (mode_active == PPFS_MODE7);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_steady;
    ce && $stable(pin_in[PPFS_P4]);
  endsequence

  AST_P4_NEVER_DRIVEN: assert property (pin_oe[PPFS_P4] == 8'h00)
    else $error("input-only port driven");
  AST_PULLUP_PORTS: assert property ((pin_pullup_en[PPFS_P3] | pin_pullup_en[PPFS_PG]) == 8'h00)
    else $error("pull-up outside ports A to E");
  AST_PULLUP_UNDRIVEN: assert property ((pin_pullup_en & pin_oe) == '0)
    else $error("pull-up on a driven pin");
  AST_RESET_IDLE: assert property (disable iff (1'b0) !rst_n && rst_seen_q |->
    fn_in == PPFS_FN_IDLE && pin_oe == '0)
    else $error("outputs not idle in reset");
  AST_BUS_RELEASE: assert property (rdy && ce && !m7 && ctrl.bus_release_enable |=>
    pin_oe[PPFS_PF][1] && !pin_oe[PPFS_PF][0] && pin_out[PPFS_PF][1] == $past(bus.bus_ack_n))
    else $error("bus acknowledge pin wrong");
  AST_ADDR_BC: assert property (rdy && ce && !m7 |=> pin_oe[PPFS_PB] == 8'hFF &&
    pin_out[PPFS_PB] == $past(bus.addr[15:8]) && pin_out[PPFS_PC] == $past(bus.addr[7:0]))
    else $error("address not on ports B and C");
  AST_ADDR_A_LOW: assert property (rdy && ce && !mode_active[1] |=> pin_oe[PPFS_PA][3:0] == 4'hF &&
    pin_out[PPFS_PA][3:0] == $past(bus.addr[19:16]))
    else $error("lower port A not address");
  AST_LOW_COLUMN: assert property (rdy && ce && !m7 && ctrl.access_16bit &&
    ctrl.refresh_dram_type_field inside {[PPFS_DRAM_LO:PPFS_DRAM_HI]} |=>
    pin_oe[PPFS_PF][2] && pin_out[PPFS_PF][2] == $past(bus.low_column_strobe_n))
    else $error("low column strobe not out");
  AST_ADDR_STROBE: assert property (rdy && ce && !m7 && !ctrl.addr_strobe_disable |=>
    pin_oe[PPFS_PF][6] && pin_out[PPFS_PF][6] == $past(bus.address_strobe_n))
    else $error("address strobe not out");
  AST_CS1: assert property (rdy && ce && !m7 && ctrl.chip_select_1_6_7_enable |=>
    pin_oe[PPFS_PG][3] && pin_out[PPFS_PG][3] == $past(bus.chip_select_n[1]))
    else $error("chip select 1 not out");
  AST_P4_READ: assert property (rdy ##0 s_steady [*6] |->
    pin_state[PPFS_P4] == pin_in[PPFS_P4])
    else $error("input-only port read wrong");
endmodule // ppfs_port_pin_function_select_asserts

bind ppfs_port_pin_function_select ppfs_port_pin_function_select_asserts #(
  .PORT_W(PORT_W),
  .ROMLESS(ROMLESS)
) i_ppfs_port_pin_function_select_asserts (
  .clk(clk),
  .rst_n(rst_n),
  .ce(ce),
  .mode_pins(mode_pins),
  .wr(wr),
  .ctrl(ctrl),
  .bus(bus),
  .pin_in(pin_in),
  .pin_out(pin_out),
  .pin_oe(pin_oe),
  .pin_pullup_en(pin_pullup_en),
  .pin_state(pin_state),
  .fn_in(fn_in),
  .mode_active(mode_active)
);

// ### bench/ppfs_pin_env.sv
// external pin model: driven level, else pull-up, else the far device
module ppfs_pin_env
  import ppfs_pkg::*;
(
  input wire ppfs_port_arr_t pin_out,
  input wire ppfs_port_arr_t pin_oe,
  input wire ppfs_port_arr_t pin_pullup_en,
  input wire ppfs_port_arr_t ext,
  output ppfs_port_arr_t pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // an open-drain pin with oe off floats to pull-up or far level
  assign pin_in = (pin_out & pin_oe) | (~pin_oe & pin_pullup_en) | (~pin_oe & ~pin_pullup_en & ext);
endmodule // ppfs_pin_env

// ### bench/tb.sv
// self-checking bench for the port pin function selector
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ppfs_pkg::*;
  logic clk, rst_n, ce;
  logic [2:0] mode_pins;
  logic [1:0] mode_active;
  ppfs_wr_t wr;
  ppfs_ctrl_t ctrl;
  ppfs_bus_t bus;
  ppfs_fn_in_t fn_in;
  ppfs_port_arr_t pin_in, pin_out, pin_oe, pin_pu, pin_state, ext;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;

  ppfs_port_pin_function_select i_ppfs_port_pin_function_select (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .mode_pins(mode_pins),
    .wr(wr),
    .ctrl(ctrl),
    .bus(bus),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .pin_pullup_en(pin_pu),
    .pin_state(pin_state),
    .fn_in(fn_in),
    .mode_active(mode_active)
  );
  ppfs_pin_env i_ppfs_pin_env (
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .pin_pullup_en(pin_pu),
    .ext(ext),
    .pin_in(pin_in)
  );

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one write command; effect lands two edges later
  task automatic wreg(input ppfs_wr_kind_t k, input logic [3:0] p, input logic [7:0] d);
    @(posedge clk);
    wr <= '{1'h1, k, p, d};
    @(posedge clk);
    wr.wr_en <= 1'h0;
    tick(3);
  endtask

  task automatic do_reset(input logic [2:0] m);
    @(posedge clk);
    rst_n <= 1'h0;
    mode_pins <= m;
    tick(8);
    chk("fn idle", 8'(fn_in), 8'h3F);
    chk("oe rst", pin_oe[PPFS_PF], 8'h00);
    rst_n <= 1'h1;
    tick(20);
  endtask

  initial begin
    rst_n = 1'h0;
    ce = 1'h1;
    mode_pins = 3'h0;
    wr = '{1'h0, PPFS_WR_LATCH, 4'h0, 8'h00};
    ctrl = '0;
    bus = '{24'h5A3C96, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 4'hA};
    ext = '1;
    ext[PPFS_P4] = 8'h96;
    ext[PPFS_PA] = 8'h6F;
    ext[PPFS_P1] = 8'hC6;
    ext[PPFS_PD] = 8'h00;
    ext[PPFS_PF] = 8'hFB;
    ext[PPFS_P5] = 8'hF7;
    do_reset(3'h0);
    // mode 4 after-reset functions
    chk("mode", 8'(mode_active), 8'h00);
    chk("pf oe", pin_oe[PPFS_PF] & 8'hC7, 8'hC0);
    chk("pf out", pin_out[PPFS_PF] & 8'hC0, 8'h80);
    chk("pg oe", pin_oe[PPFS_PG], 8'h10);
    chk("pa oe", pin_oe[PPFS_PA], 8'h0F);
    chk("pa out", pin_out[PPFS_PA] & 8'h0F, 8'h0A);
    chk("pb out", pin_out[PPFS_PB], 8'h3C);
    chk("irq", 8'(fn_in.irq_a_n), 8'h06);
    // upper port A: mixed address and latch
    ctrl.addr_line_enable_top <= 3'h2;
    wreg(PPFS_WR_LATCH, 4'(PPFS_PA), 8'hB0);
    wreg(PPFS_WR_DIR, 4'(PPFS_PA), 8'hF0);
    chk("pa mix", pin_out[PPFS_PA], 8'hFA);
    // read view, latch and direction
    wreg(PPFS_WR_DIR, 4'(PPFS_P1), 8'h0F);
    wreg(PPFS_WR_LATCH, 4'(PPFS_P1), 8'h33);
    chk("p1 oe", pin_oe[PPFS_P1], 8'h0F);
    chk("p1 out", pin_out[PPFS_P1] & 8'h0F, 8'h03);
    chk("p1 read", pin_state[PPFS_P1], 8'hC3);
    // pull-ups, including a refused port
    wreg(PPFS_WR_PULLUP, 4'(PPFS_PD), 8'hFF);
    wreg(PPFS_WR_DIR, 4'(PPFS_PD), 8'h0F);
    wreg(PPFS_WR_PULLUP, 4'(PPFS_P1), 8'hFF);
    tick(4);
    chk("pd pu", pin_pu[PPFS_PD], 8'hF0);
    chk("p1 pu", pin_pu[PPFS_P1], 8'h00);
    chk("pd read", pin_state[PPFS_PD], 8'hF0);
    // open drain on port 3, refused on port 1
    wreg(PPFS_WR_DIR, 4'(PPFS_P3), 8'h3F);
    wreg(PPFS_WR_LATCH, 4'(PPFS_P3), 8'h0F);
    wreg(PPFS_WR_ODRAIN, 4'(PPFS_P3), 8'h03);
    wreg(PPFS_WR_ODRAIN, 4'(PPFS_P1), 8'hFF);
    chk("p3 od", pin_oe[PPFS_P3], 8'h3C);
    chk("p1 od", pin_oe[PPFS_P1], 8'h0F);
    // port F bus release and wait input
    ctrl.bus_release_enable <= 1'h1;
    ctrl.wait_input_enable <= 1'h1;
    tick(8);
    chk("pf brl", pin_oe[PPFS_PF] & 8'h07, 8'h02);
    chk("ack", pin_out[PPFS_PF] & 8'h02, 8'h00);
    chk("wait", 8'(fn_in.wait_n), 8'h00);
    chk("external_bus_request", 8'(fn_in.external_bus_request_n), 8'h01);
    ctrl.wait_input_enable <= 1'h0;
    ctrl.bus_drop_out_enable <= 1'h1;
    ctrl.bus_drop_pin_select <= 1'h1;
    tick(3);
    chk("p5 oe", pin_oe[PPFS_P5] & 8'h08, 8'h08);
    chk("p5 out", pin_out[PPFS_P5] & 8'h08, 8'h00);
    chk("pf2 off", pin_oe[PPFS_PF] & 8'h04, 8'h00);
    ctrl.refresh_dram_type_field <= 3'h3;
    ctrl.access_16bit <= 1'h1;
    tick(3);
    chk("low_column_strobe", pin_oe[PPFS_PF] & 8'h04, 8'h04);
    ctrl.refresh_dram_type_field <= 3'h4;
    tick(3);
    chk("low_column_strobe off", pin_oe[PPFS_PF] & 8'h04, 8'h00);
    // wait input moved to the port 5 pin, held low by the far side
    ctrl.bus_drop_out_enable <= 1'h0;
    ctrl.wait_input_enable <= 1'h1;
    ctrl.wait_pin_select <= 1'h1;
    tick(8);
    chk("wait p5", 8'(fn_in.wait_n), 8'h00);
    chk("p5 in", pin_oe[PPFS_P5] & 8'h08, 8'h00);
    // chip selects: general output, then select, then input
    wreg(PPFS_WR_DIR, 4'(PPFS_PG), 8'h1E);
    chk("pg gp", pin_out[PPFS_PG] & 8'h0E, 8'h00);
    ctrl.chip_select_1_6_7_enable <= 1'h1;
    ctrl.chip_select_2_5_enable <= 1'h1;
    tick(3);
    chk("pg cs", pin_out[PPFS_PG] & 8'h1E, 8'h0A);
    wreg(PPFS_WR_DIR, 4'(PPFS_PG), 8'h18);
    chk("pg in", pin_oe[PPFS_PG], 8'h18);
    ctrl.addr_strobe_disable <= 1'h1;
    ctrl.dram_space_set <= 1'h1;
    tick(3);
    chk("as off", pin_oe[PPFS_PF] & 8'h40, 8'h00);
    chk("pg cas", pin_oe[PPFS_PG] & 8'h01, 8'h01);
    // clock enable low freezes the outputs until it returns
    ce <= 1'h0;
    ctrl.addr_strobe_disable <= 1'h0;
    tick(3);
    chk("ce hold", pin_oe[PPFS_PF] & 8'h40, 8'h00);
    ce <= 1'h1;
    tick(3);
    chk("as on", pin_oe[PPFS_PF] & 8'h40, 8'h40);
    // mode 7: takeovers ignored, the clock pin still follows its direction bit
    do_reset(3'h3);
    chk("mode7", 8'(mode_active), 8'h03);
    chk("pf7 oe", pin_oe[PPFS_PF] & 8'hC7, 8'h00);
    chk("pa7", pin_oe[PPFS_PA], 8'h00);
    chk("pb7", pin_oe[PPFS_PB], 8'h00);
    chk("pg7", pin_oe[PPFS_PG], 8'h00);
    wreg(PPFS_WR_DIR, 4'(PPFS_PF), 8'h80);
    chk("clk7", pin_out[PPFS_PF] & 8'h80, 8'h80);
    // mode 6: lower port A waits for direction
    do_reset(3'h2);
    chk("pa6", pin_oe[PPFS_PA] & 8'h0F, 8'h00);
    chk("pf6", pin_oe[PPFS_PF] & 8'h80, 8'h80);
    chk("pg6", pin_oe[PPFS_PG] & 8'h10, 8'h00);
    wreg(PPFS_WR_DIR, 4'(PPFS_PA), 8'h0F);
    chk("pa6 adr", pin_out[PPFS_PA] & 8'h0F, 8'h0A);
    report_and_stop();
  end
endmodule // tb
